/* hdl/bsfr_pkg.sv */
// constants and types shared by the bit-synchronous frame receiver
package bsfr_pkg;
    // link framing patterns, bits are taken least significant first
    localparam logic [7:0] BSFR_FLAG = 8'h7E;
    localparam logic [7:0] BSFR_BCAST_ADDR = 8'hFF;
    localparam logic [2:0] BSFR_STUFF_ONES = 3'h5;
    localparam logic [2:0] BSFR_ABORT_ONES = 3'h7;
    // delay line ahead of the assembler and its checker tap
    localparam int BSFR_DQ_DEPTH = 8;
    localparam logic [3:0] BSFR_DQ_FULL = 4'h8;
    localparam logic [3:0] BSFR_CRC_LAG = 4'h6;
    localparam int BSFR_CRC_TAP = 5;
    // check sequence
    localparam logic [15:0] BSFR_CRC_POLY = 16'h1021;
    localparam logic [15:0] BSFR_CRC_GOOD = 16'h1D0F;
    localparam logic [15:0] BSFR_CRC_ONES = 16'hFFFF;
    localparam logic [15:0] BSFR_CRC_ZERO = 16'h0000;
    // character sizes
    localparam logic [3:0] BSFR_ADDR_BITS = 4'h8;
    localparam logic [3:0] BSFR_MIN_LEN = 4'h5;
    // layout of one buffer entry
    localparam int BSFR_ENTRY_W = 13;
    localparam int BSFR_E_EOF = 12;
    localparam int BSFR_E_CRCERR = 11;
    localparam int BSFR_E_RES_HI = 10;
    localparam int BSFR_E_RES_LO = 8;
    // receive interrupt modes
    typedef enum logic [1:0] {
        BSFR_INT_NONE,
        BSFR_INT_FIRST,
        BSFR_INT_EVERY
    } bsfr_int_mode_t;
    // receiver phases
    typedef enum logic [1:0] {
        BSFR_HUNT,
        BSFR_ADDR,
        BSFR_DATA,
        BSFR_SKIP
    } bsfr_state_t;
endpackage : bsfr_pkg

/* hdl/bsfr_skid_buf.sv */
// two-entry buffer with valid/ready on both sides, head held in flops
`timescale 1ns/1ps
module bsfr_skid_buf #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] head, next_head; // oldest entry, drives the output
    logic [WIDTH-1:0] tail, next_tail; // second entry
    logic head_v, next_head_v;
    logic tail_v, next_tail_v;
    logic pop, push;

    // next state: pop moves tail to head, push fills the first free slot
    always_comb begin
        pop = out_ready & head_v;
        push = in_valid & ~tail_v;
        next_head = head;
        next_tail = tail;
        next_head_v = head_v;
        next_tail_v = tail_v;
        if (pop && tail_v) begin
            next_head = tail;
            next_tail_v = 1'b0;
        end else if (pop) begin
            // tail empty: a push lands straight in the head
            next_head = in_data;
            next_head_v = push;
        end else if (push && !head_v) begin
            next_head = in_data;
            next_head_v = 1'b1;
        end else if (push) begin
            next_tail = in_data;
            next_tail_v = 1'b1;
        end
    end

    // registers only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            head <= '0;
            tail <= '0;
            head_v <= 1'b0;
            tail_v <= 1'b0;
        end else begin
            head <= next_head;
            tail <= next_tail;
            head_v <= next_head_v;
            tail_v <= next_tail_v;
        end
    end

    // full only when the tail is taken, so ready is a flop too
    assign in_ready = ~tail_v;
    assign out_valid = head_v;
    assign out_data = head;
endmodule : bsfr_skid_buf

/* hdl/bsfr_receiver.sv */
// bit-synchronous frame receiver: flag hunt, destuffing, address filter, check, status
`timescale 1ns/1ps
module bsfr_receiver
    import bsfr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // serial link pins
    input wire logic rx_clk_pin,
    input wire logic rx_data_pin,
    // configuration
    input wire logic rx_enable,
    input wire logic bit_sync_mode,
    input wire logic addr_search,
    input wire logic [1:0] char_len_sel,
    input wire logic [7:0] station_addr,
    input wire bsfr_pkg::bsfr_int_mode_t int_mode,
    input wire logic status_vector_en,
    // command pulses
    input wire logic hunt_cmd,
    input wire logic crc_reset_cmd,
    input wire logic error_reset_cmd,
    input wire logic ext_reset_cmd,
    input wire logic rearm_cmd,
    // receive buffer read side
    input wire logic read_strobe,
    output logic char_avail,
    output logic [7:0] rx_char,
    output logic rx_eof,
    output logic rx_crc_err,
    output logic [2:0] rx_residue,
    // status and requests
    output logic rx_overrun,
    output logic in_hunt,
    output logic abort_status,
    output logic rx_int_req,
    output logic special_int_req,
    output logic ext_int_req,
    output logic vector_mod
);
    import bsfr_pkg::*;

    // link synchronisers; first stages feed only the second stages
    logic clk_s1, clk_s2, clk_s3;
    logic dat_s1, dat_s2;
    logic bit_tick; // one sys_clk per rising edge of the link clock

    // bit engine state
    bsfr_state_t state, next_state;
    logic [7:0] win, next_win; // last eight raw bits, newest at the top
    logic [2:0] ones, next_ones; // run of ones, saturating at seven
    logic [7:0] dq, next_dq; // destuffed bits waiting, newest at bit 0
    logic [3:0] dq_cnt, next_dq_cnt;
    logic [7:0] sr, next_sr; // character assembler, fills from the top
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [15:0] crc, next_crc;
    logic abort_lvl, next_abort_lvl; // line currently in a run of seven or more ones
    logic push_v, next_push_v; // one-cycle push into the buffer
    logic [BSFR_ENTRY_W-1:0] push_d, next_push_d;
    logic ovr_evt, next_ovr_evt;

    // interrupt and status state
    logic overrun_lat, next_overrun_lat;
    logic rx_int, next_rx_int;
    logic spec_int, next_spec_int;
    logic vec, next_vec;
    logic ext_pend, next_ext_pend;
    logic abort_stat, next_abort_stat;
    logic armed, next_armed; // first-character interrupt still owed
    logic first_d, next_first_d; // mode was first-character last cycle
    logic avail_d, pop_d;

    // buffer ports
    logic buf_ready;
    logic buf_valid;
    logic [BSFR_ENTRY_W-1:0] buf_head;
    logic pop;

    // engine scratch
    logic b, keep, flag_det, closing, crc_fb;
    logic [3:0] len;
    logic [7:0] byte_now, char_out;
    logic [7:0] part_out;

    // two flops per pin, a third on the clock only for its edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            dat_s1 <= 1'b1;
            dat_s2 <= 1'b1;
        end else begin
            clk_s1 <= rx_clk_pin;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            dat_s1 <= rx_data_pin;
            dat_s2 <= dat_s1;
        end
    end

    // data passed the same two stages, so it is sampled at the clock's rising edge
    assign bit_tick = clk_s2 & ~clk_s3;

    // bit engine: flag and abort detection, destuffing, assembly, checker
    always_comb begin
        next_state = state;
        next_win = win;
        next_ones = ones;
        next_dq = dq;
        next_dq_cnt = dq_cnt;
        next_sr = sr;
        next_bit_cnt = bit_cnt;
        next_crc = crc;
        next_abort_lvl = abort_lvl;
        next_push_v = 1'b0;
        next_push_d = push_d;
        next_ovr_evt = 1'b0;
        b = dat_s2;
        len = BSFR_MIN_LEN + {2'h0, char_len_sel};
        keep = 1'b0;
        flag_det = 1'b0;
        closing = 1'b0;
        crc_fb = 1'b0;
        byte_now = {b, sr[7:1]};
        char_out = 8'h00;
        part_out = sr >> (BSFR_ADDR_BITS - bit_cnt);
        if (bit_tick) begin
            next_win = {b, win[7:1]};
            next_ones = b ? ((ones == BSFR_ABORT_ONES) ? ones : ones + 3'h1) : 3'h0;
            flag_det = (next_win == BSFR_FLAG);
            next_abort_lvl = (next_ones == BSFR_ABORT_ONES);
            // a zero after five ones is stuffing, a sixth one is never data
            keep = b ? (ones < BSFR_STUFF_ONES) : (ones != BSFR_STUFF_ONES);
        end
        if (!rx_enable || hunt_cmd || (bit_tick && next_abort_lvl)) begin
            next_state = BSFR_HUNT;
            next_dq_cnt = 4'h0;
            next_bit_cnt = 4'h0;
            next_crc = bit_sync_mode ? BSFR_CRC_ONES : BSFR_CRC_ZERO;
        end else if (bit_tick && flag_det) begin
            // a flag after frame content closes it; flag after flag is only idle fill
            closing = (state == BSFR_DATA) && (dq_cnt == BSFR_DQ_FULL);
            if (closing) begin
                next_push_v = buf_ready;
                next_ovr_evt = ~buf_ready;
                next_push_d = {1'b1, (crc != BSFR_CRC_GOOD), bit_cnt[2:0], part_out};
            end
            // every flag opens a fresh frame and presets the checker
            next_state = addr_search ? BSFR_ADDR : BSFR_DATA;
            next_dq_cnt = 4'h0;
            next_bit_cnt = 4'h0;
            next_crc = BSFR_CRC_ONES;
        end else if (bit_tick && keep && state != BSFR_HUNT) begin
            next_dq = {dq[6:0], b};
            next_dq_cnt = (dq_cnt == BSFR_DQ_FULL) ? dq_cnt : dq_cnt + 4'h1;
            // checker lags six bits so a closing flag never enters it
            if (dq_cnt >= BSFR_CRC_LAG) begin
                crc_fb = crc[15] ^ dq[BSFR_CRC_TAP];
                next_crc = {crc[14:0], 1'b0} ^ (crc_fb ? BSFR_CRC_POLY : BSFR_CRC_ZERO);
            end
            // the assembler takes the bit leaving the delay line
            if (dq_cnt == BSFR_DQ_FULL) begin
                byte_now = {dq[BSFR_DQ_DEPTH-1], sr[7:1]};
                next_sr = byte_now;
                next_bit_cnt = bit_cnt + 4'h1;
                if (state == BSFR_ADDR && next_bit_cnt == BSFR_ADDR_BITS) begin
                    // eight bits regardless of the programmed length
                    next_bit_cnt = 4'h0;
                    if (byte_now == station_addr || byte_now == BSFR_BCAST_ADDR) begin
                        next_state = BSFR_DATA;
                        next_push_v = buf_ready;
                        next_ovr_evt = ~buf_ready;
                        next_push_d = {5'h00, byte_now};
                    end else begin
                        next_state = BSFR_SKIP;
                    end
                end else if (state == BSFR_DATA && next_bit_cnt >= len) begin
                    // right-justified; surplus upper bits are the next character's first bits
                    char_out = (byte_now >> (BSFR_ADDR_BITS - len))
                        | ({5'h00, dq[4], dq[5], dq[6]} << len);
                    next_bit_cnt = 4'h0;
                    next_push_v = buf_ready;
                    next_ovr_evt = ~buf_ready;
                    next_push_d = {5'h00, char_out};
                end else if (state == BSFR_SKIP) begin
                    next_bit_cnt = 4'h0;
                end
            end
        end
        // a software check reset overrides the running value
        if (crc_reset_cmd) begin
            next_crc = bit_sync_mode ? BSFR_CRC_ONES : BSFR_CRC_ZERO;
        end
    end

    // bit engine registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= BSFR_HUNT;
            win <= 8'h00;
            ones <= 3'h0;
            dq <= 8'h00;
            dq_cnt <= 4'h0;
            sr <= 8'h00;
            bit_cnt <= 4'h0;
            crc <= BSFR_CRC_ONES;
            abort_lvl <= 1'b0;
            push_v <= 1'b0;
            push_d <= '0;
            ovr_evt <= 1'b0;
        end else begin
            state <= next_state;
            win <= next_win;
            ones <= next_ones;
            dq <= next_dq;
            dq_cnt <= next_dq_cnt;
            sr <= next_sr;
            bit_cnt <= next_bit_cnt;
            crc <= next_crc;
            abort_lvl <= next_abort_lvl;
            push_v <= next_push_v;
            push_d <= next_push_d;
            ovr_evt <= next_ovr_evt;
        end
    end

    // holding buffer; a slow reader backs up into the overrun flag, not a lost flag
    bsfr_skid_buf #(
        .WIDTH(BSFR_ENTRY_W)
    ) u_buf (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(push_v),
        .in_data(push_d),
        .in_ready(buf_ready),
        .out_valid(buf_valid),
        .out_ready(pop),
        .out_data(buf_head)
    );

    // a read with nothing available is ignored
    assign pop = read_strobe & buf_valid;

    // receive, special and external requests
    always_comb begin
        logic arrive;
        logic special;
        logic hit;
        arrive = 1'b0;
        special = 1'b0;
        hit = 1'b0;
        // a new character reached the head: first one, or the one behind a read
        arrive = buf_valid & (~avail_d | pop_d);
        special = buf_head[BSFR_E_EOF] | overrun_lat;
        next_first_d = (int_mode == BSFR_INT_FIRST);
        // overrun sticks until error reset; a new event wins over the clear
        next_overrun_lat = ovr_evt | (overrun_lat & ~error_reset_cmd);
        // armed on selecting the mode or on re-arm; a held character counts
        hit = armed & buf_valid & (int_mode == BSFR_INT_FIRST);
        next_armed = rearm_cmd | (~first_d & next_first_d) | (armed & ~hit);
        next_rx_int = (rx_int & ~pop) | hit
            | (arrive & (int_mode == BSFR_INT_EVERY));
        next_spec_int = (spec_int & ~pop)
            | (arrive & special & (int_mode != BSFR_INT_NONE));
        next_vec = next_spec_int & status_vector_en;
        // status follows the line only while unlatched, so both edges interrupt
        next_ext_pend = ext_pend;
        next_abort_stat = abort_stat;
        if (!ext_pend && abort_lvl != abort_stat) begin
            next_ext_pend = 1'b1;
            next_abort_stat = abort_lvl;
        end else if (ext_pend && ext_reset_cmd) begin
            next_ext_pend = 1'b0;
        end
    end

    // interrupt registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            overrun_lat <= 1'b0;
            rx_int <= 1'b0;
            spec_int <= 1'b0;
            vec <= 1'b0;
            ext_pend <= 1'b0;
            abort_stat <= 1'b0;
            armed <= 1'b0;
            first_d <= 1'b0;
            avail_d <= 1'b0;
            pop_d <= 1'b0;
        end else begin
            overrun_lat <= next_overrun_lat;
            rx_int <= next_rx_int;
            spec_int <= next_spec_int;
            vec <= next_vec;
            ext_pend <= next_ext_pend;
            abort_stat <= next_abort_stat;
            armed <= next_armed;
            first_d <= next_first_d;
            avail_d <= buf_valid;
            pop_d <= pop;
        end
    end

    // hunt indication registered from the next state so it is a plain flop output in step with state
    logic hunt_q;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hunt_q <= 1'b1;
        end else begin
            hunt_q <= (next_state == BSFR_HUNT);
        end
    end

    // outputs, all straight from flops
    assign char_avail = buf_valid;
    assign rx_char = buf_head[7:0];
    assign rx_eof = buf_head[BSFR_E_EOF];
    assign rx_crc_err = buf_head[BSFR_E_CRCERR];
    assign rx_residue = buf_head[BSFR_E_RES_HI:BSFR_E_RES_LO];
    assign rx_overrun = overrun_lat;
    assign in_hunt = hunt_q;
    assign abort_status = abort_stat;
    assign rx_int_req = rx_int;
    assign special_int_req = spec_int;
    assign ext_int_req = ext_pend;
    assign vector_mod = vec;
endmodule : bsfr_receiver

/* verification/bsfr_receiver_monitor.sv */
// concurrent checks on the ports of the bit-synchronous frame receiver
`timescale 1ns/1ps
module bsfr_receiver_monitor
    import bsfr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration and commands
    input wire logic rx_enable,
    input wire bsfr_pkg::bsfr_int_mode_t int_mode,
    input wire logic status_vector_en,
    input wire logic hunt_cmd,
    input wire logic error_reset_cmd,
    input wire logic ext_reset_cmd,
    input wire logic read_strobe,
    // buffer head
    input wire logic char_avail,
    input wire logic [7:0] rx_char,
    input wire logic rx_eof,
    // status and requests
    input wire logic rx_overrun,
    input wire logic in_hunt,
    input wire logic abort_status,
    input wire logic rx_int_req,
    input wire logic special_int_req,
    input wire logic ext_int_req,
    input wire logic vector_mod
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_ENABLE_HUNT: assert property (!rx_enable [*2] |-> in_hunt)
        else $error("receiver out of hunt while disabled");
    AST_HUNT_CMD: assert property (hunt_cmd |-> ##[1:2] in_hunt)
        else $error("hunt command did not restart hunt");
    AST_OVR_HOLD: assert property (rx_overrun && !error_reset_cmd |=> rx_overrun)
        else $error("overrun dropped without error reset");
    // an empty buffer for three cycles leaves no drop that could still set overrun
    AST_OVR_CLEAR: assert property ((!char_avail [*3]) ##0 error_reset_cmd |=> !rx_overrun)
        else $error("error reset left overrun set");
    AST_EXT_HOLD: assert property (ext_int_req && !ext_reset_cmd |=> ext_int_req)
        else $error("status request dropped without reset");
    AST_EXT_CAUSE: assert property ($rose(ext_int_req) |-> $changed(abort_status))
        else $error("status request without abort change");
    AST_HEAD_HOLD: assert property (char_avail && !read_strobe |=> char_avail && $stable(rx_char))
        else $error("head character changed without a read");
    AST_EVERY_REQ: assert property ($rose(char_avail) && int_mode == BSFR_INT_EVERY
        |=> rx_int_req)
        else $error("no receive request for new head");
    AST_EOF_SPECIAL: assert property ($rose(char_avail) && rx_eof && int_mode != BSFR_INT_NONE
        |=> special_int_req)
        else $error("no special request for end of frame");
    AST_VECTOR: assert property (special_int_req && status_vector_en |-> ##[0:1] vector_mod)
        else $error("special condition left vector unchanged");
endmodule : bsfr_receiver_monitor

/* verification/bsfr_link_model.sv */
// remote station model: flags, stuffed data, inverted check sequence, aborts
`timescale 1ns/1ps
module bsfr_link_model
    import bsfr_pkg::*;
(
    // link pins toward the receiver
    output logic rx_clk_pin,
    output logic rx_data_pin
);
    logic [15:0] crc; // running check register
    int ones; // ones since the last zero sent, flag or abort
    initial begin
        rx_clk_pin = 1'h0;
        rx_data_pin = 1'h0;
        crc = BSFR_CRC_ONES;
        ones = 0;
    end
    // one 320 ns bit; the clock stands low between frames
    task automatic put_bit(input logic b);
        rx_data_pin = b;
        #160;
        rx_clk_pin = 1'h1;
        #160;
        rx_clk_pin = 1'h0;
    endtask : put_bit
    // a zero after five ones keeps data from looking like a flag
    task automatic stuffed_bit(input logic b);
        put_bit(b);
        ones = b ? ones + 1 : 0;
        if (ones == 5) begin
            put_bit(1'h0);
            ones = 0;
        end
    endtask : stuffed_bit
    // n data bits, low first, folded into the check register
    task automatic raw(input logic [15:0] d, input int n);
        for (int i = 0; i < n; i++) begin
            crc = {crc[14:0], 1'h0} ^ ((crc[15] ^ d[i]) ? BSFR_CRC_POLY : 16'h0000);
            stuffed_bit(d[i]);
        end
    endtask : raw
    // flags are never stuffed and preset the check register
    task automatic flag_seq();
        for (int i = 0; i < 8; i++) begin
            put_bit(BSFR_FLAG[i]);
        end
        ones = 0;
        crc = BSFR_CRC_ONES;
    endtask : flag_seq
    // eight ones in a row
    task automatic send_abort();
        repeat (8) put_bit(1'h1);
        ones = 0;
    endtask : send_abort
    // whole frame; bad flips the first check bit; line toggles once idle
    task automatic frame(input logic [15:0] d, input int n, input logic bad);
        logic [15:0] c;
        flag_seq();
        raw(d, n);
        c = ~crc;
        for (int i = 15; i >= 0; i--) begin
            stuffed_bit(c[i] ^ (bad && i == 15));
        end
        flag_seq();
        rx_data_pin = ~rx_data_pin;
    endtask : frame
endmodule : bsfr_link_model

/* verification/bsfr_receiver_tb.sv */
// self-checking bench for the bit-synchronous frame receiver
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module bsfr_receiver_tb;
    import bsfr_pkg::*;
    logic sys_clk, rst, rx_clk_pin, rx_data_pin; // clock, reset, link
    logic rx_enable, addr_search, vec_en, read_strobe; // controls
    logic [1:0] char_len_sel; // length select
    logic [7:0] station_addr; // station address
    bsfr_int_mode_t int_mode; // interrupt mode
    logic [4:0] cmds; // hunt, check reset, error reset, ext reset, re-arm
    logic char_avail, rx_eof, rx_crc_err, rx_overrun, in_hunt, abort_status;
    logic rx_int_req, special_int_req, ext_int_req, vector_mod; // requests
    logic [7:0] rx_char; // head character
    logic [2:0] rx_residue; // final partial bit count
    logic [15:0] f; // expected check bits, first sent in bit 0
    int errors, compares; // counts

    bsfr_receiver dut (.sys_clk(sys_clk), .rst(rst), .rx_clk_pin(rx_clk_pin),
        .rx_data_pin(rx_data_pin), .rx_enable(rx_enable), .bit_sync_mode(1'h1),
        .addr_search(addr_search), .char_len_sel(char_len_sel), .station_addr(station_addr),
        .int_mode(int_mode), .status_vector_en(vec_en), .hunt_cmd(cmds[0]),
        .crc_reset_cmd(cmds[1]), .error_reset_cmd(cmds[2]), .ext_reset_cmd(cmds[3]),
        .rearm_cmd(cmds[4]), .read_strobe(read_strobe), .char_avail(char_avail),
        .rx_char(rx_char), .rx_eof(rx_eof), .rx_crc_err(rx_crc_err), .rx_residue(rx_residue),
        .rx_overrun(rx_overrun), .in_hunt(in_hunt), .abort_status(abort_status),
        .rx_int_req(rx_int_req), .special_int_req(special_int_req),
        .ext_int_req(ext_int_req), .vector_mod(vector_mod));
    bsfr_link_model lnk (.rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin));

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    // let n edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // one-cycle command pulse
    task automatic command(input int k);
        @(posedge sys_clk);
        cmds <= 5'h01 << k;
        @(posedge sys_clk);
        cmds <= 5'h00;
        tick(1);
    endtask : command
    // check bits a good sender appends, in sending order
    function automatic logic [15:0] expected_fcs(input logic [15:0] d, input int n);
        logic [15:0] c;
        logic [15:0] r;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c = {c[14:0], 1'h0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        for (int i = 0; i < 16; i++) begin
            r[i] = ~c[15 - i];
        end
        return r;
    endfunction : expected_fcs
    // read the head only once a character is there, as polling software must
    task automatic read_chk(input logic [7:0] ch, input logic eof, input logic [2:0] res,
                            input logic ce, input logic irq, input logic spc);
        int n;
        n = 0;
        while (char_avail !== 1'h1 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n == 3000) begin
            errors++;
            complete_run();
        end
        tick(2); // requests follow a new head by a cycle
        `CHK("rx_char", ch, rx_char)
        `CHK("rx_eof", eof, rx_eof)
        if (eof) begin
            `CHK("rx_residue", res, rx_residue)
            `CHK("rx_crc_err", ce, rx_crc_err)
        end
        `CHK("rx_int_req", irq, rx_int_req)
        `CHK("special_int_req", spc, special_int_req)
        `CHK("vector_mod", spc, vector_mod)
        @(posedge sys_clk);
        read_strobe <= 1'h1;
        @(posedge sys_clk);
        read_strobe <= 1'h0;
        tick(1);
    endtask : read_chk
    // verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        rst = 1'h1;
        {rx_enable, addr_search, read_strobe} = 3'h0;
        vec_en = 1'h1;
        char_len_sel = 2'h3;
        station_addr = 8'h3C;
        int_mode = BSFR_INT_EVERY;
        cmds = 5'h00;
        errors = 0;
        compares = 0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'h0;
        tick(3);
        rx_enable <= 1'h1;
        lnk.raw(16'h5555, 16);
        tick(40);
        `CHK("char_avail", 1'h0, char_avail)
        `CHK("in_hunt", 1'h1, in_hunt)
        $display("Test no-flag done");
        addr_search <= 1'h1;
        command(1);
        f = expected_fcs(16'hF83C, 16);
        fork
            lnk.frame(16'hF83C, 16, 1'h0);
            begin
                read_chk(8'h3C, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
                read_chk(8'hF8, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
                read_chk(f[7:0], 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
                read_chk({2'h0, f[13:8]}, 1'h1, 3'h6, 1'h0, 1'h1, 1'h1);
            end
        join
        $display("Test good frame done");
        int_mode <= BSFR_INT_FIRST;
        lnk.frame(16'h5581, 16, 1'h0);
        tick(60);
        `CHK("char_avail", 1'h0, char_avail)
        f = expected_fcs(16'h81FF, 16) ^ 16'h0001;
        fork
            lnk.frame(16'h81FF, 16, 1'h1);
            begin
                read_chk(8'hFF, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
                read_chk(8'h81, 1'h0, 3'h0, 1'h0, 1'h0, 1'h0);
                read_chk(f[7:0], 1'h0, 3'h0, 1'h0, 1'h0, 1'h0);
                read_chk({2'h0, f[13:8]}, 1'h1, 3'h6, 1'h1, 1'h0, 1'h1);
            end
        join
        $display("Test filter done");
        addr_search <= 1'h0;
        char_len_sel <= 2'h0;
        command(4);
        f = expected_fcs(16'h0135, 10);
        fork
            lnk.frame(16'h0135, 10, 1'h0);
            begin
                read_chk(8'h35, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
                read_chk({f[2:0], 5'h09}, 1'h0, 3'h0, 1'h0, 1'h0, 1'h0);
                read_chk(f[7:0], 1'h0, 3'h0, 1'h0, 1'h0, 1'h0);
                read_chk(f[12:5], 1'h0, 3'h0, 1'h0, 1'h0, 1'h0);
                read_chk({4'h0, f[13:10]}, 1'h1, 3'h4, 1'h0, 1'h0, 1'h1);
            end
        join
        $display("Test short chars done");
        char_len_sel <= 2'h3;
        int_mode <= BSFR_INT_EVERY;
        lnk.frame(16'h2211, 16, 1'h0);
        tick(100);
        `CHK("rx_overrun", 1'h1, rx_overrun)
        read_chk(8'h11, 1'h0, 3'h0, 1'h0, 1'h1, 1'h0);
        read_chk(8'h22, 1'h0, 3'h0, 1'h0, 1'h1, 1'h1);
        command(2);
        `CHK("rx_overrun", 1'h0, rx_overrun)
        fork
            lnk.frame(16'h2211, 16, 1'h0);
            begin
                tick(110);
                command(0);
                `CHK("in_hunt", 1'h1, in_hunt)
            end
        join
        tick(100);
        `CHK("char_avail", 1'h0, char_avail)
        $display("Test overrun and hunt done");
        lnk.flag_seq();
        lnk.raw(16'h00A5, 8);
        lnk.send_abort();
        tick(30);
        `CHK("in_hunt", 1'h1, in_hunt)
        `CHK("abort_status", 1'h1, abort_status)
        `CHK("ext_int_req", 1'h1, ext_int_req)
        command(3);
        `CHK("ext_int_req", 1'h0, ext_int_req)
        lnk.put_bit(1'h0);
        tick(30);
        `CHK("ext_int_req", 1'h1, ext_int_req)
        `CHK("abort_status", 1'h0, abort_status)
        $display("Test abort done");
        complete_run();
    end
endmodule : bsfr_receiver_tb

bind bsfr_receiver bsfr_receiver_monitor mon (.sys_clk(sys_clk), .rst(rst),
    .rx_enable(rx_enable), .int_mode(int_mode), .status_vector_en(status_vector_en),
    .hunt_cmd(hunt_cmd), .error_reset_cmd(error_reset_cmd), .ext_reset_cmd(ext_reset_cmd),
    .read_strobe(read_strobe), .char_avail(char_avail), .rx_char(rx_char), .rx_eof(rx_eof),
    .rx_overrun(rx_overrun), .in_hunt(in_hunt), .abort_status(abort_status),
    .rx_int_req(rx_int_req), .special_int_req(special_int_req), .ext_int_req(ext_int_req),
    .vector_mod(vector_mod));
